//--- common/mux_cfg_defs.svh
// Field positions, codes and reset values for the input multiplexer decoder
`ifndef MUX_CFG_DEFS_SVH
`define MUX_CFG_DEFS_SVH

`define INCC_LSB       10
`define INCC_MSB       12
`define SEL_LSB        7
`define SEL_MSB        9
`define REF_LSB        3
`define REF_MSB        5
`define CFG_W          14
`define CFG_RESET      14'h3FFF
`define INCC_SINGLE    3'h7
`define INCC_COM_BIP   3'h2
`define INCC_COM_UNI   3'h6
`define INCC_PAIR_BIP  2'h0
`define INCC_PAIR_UNI  2'h2
`define REF_INT_2V5    3'h0
`define REF_INT_4V096  3'h1
`define REF_EXT_TEMP   3'h2
`define REF_EXT_BUF_T  3'h3
`define REF_EXT        3'h6
`define REF_EXT_BUF    3'h7
`define CH_TEMP        4'h8
`define ADDR_CFG       4'h0
`define ADDR_SAMPLE    4'h1
`define ADDR_STATUS    4'h2

`endif

//--- common/mux_cfg_pkg.sv
// Types shared by the input multiplexer decoder
package mux_cfg_pkg;
	typedef enum logic [2:0] {
		MODE_SINGLE,
		MODE_COM_BIP,
		MODE_COM_UNI,
		MODE_PAIR_BIP,
		MODE_PAIR_UNI
	} in_mode_t;

	typedef enum {
		ST_IDLE,
		ST_ACQ,
		ST_CONV
	} samp_state_t;

	typedef struct packed {
		logic [7:0] pos_sel;
		logic [7:0] neg_sel;
		logic       neg_is_com;
		logic       neg_is_gnd;
		logic       mid_sense;
		logic       twos_comp;
		logic       ref_int_en;
		logic       ref_4v096;
		logic       buf_en;
		logic       temp_en;
	} mux_setting_t;
endpackage

//--- common/cfg_dec_if.sv
// Carries a configuration word to the decoder and its settings back
interface cfg_dec_if;
	import mux_cfg_pkg::*;
	logic [13:0]  cfg;
	logic         seq_drive;
	logic [2:0]   seq_ch;
	logic         temp_pick;
	mux_setting_t setting;
	modport ctrl (output cfg, output seq_drive, output seq_ch, output temp_pick, input setting);
	modport dec (input cfg, input seq_drive, input seq_ch, input temp_pick, output setting);
endinterface

//--- src/cfg_decode.sv
// Combinational decode of a configuration word into multiplexer and reference settings
`include "mux_cfg_defs.svh"
module cfg_decode
	import mux_cfg_pkg::*;
(
	cfg_dec_if.dec d
);
	logic [2:0] incc;
	logic [2:0] sel;
	logic [2:0] refs;
	logic [2:0] pos;
	in_mode_t   mode;
	mux_setting_t s;

	assign incc = d.cfg[`INCC_MSB:`INCC_LSB];
	assign sel  = d.seq_drive ? d.seq_ch : d.cfg[`SEL_MSB:`SEL_LSB];
	assign refs = d.cfg[`REF_MSB:`REF_LSB];

	always_comb begin
		if (incc == `INCC_SINGLE) begin
			mode = MODE_SINGLE;
		end else if (incc == `INCC_COM_BIP) begin
			mode = MODE_COM_BIP;
		end else if (incc == `INCC_COM_UNI) begin
			mode = MODE_COM_UNI;
		end else if (incc[2:1] == `INCC_PAIR_BIP) begin
			mode = MODE_PAIR_BIP;
		end else if (incc[2:1] == `INCC_PAIR_UNI) begin
			mode = MODE_PAIR_UNI;
		end else begin
			mode = MODE_SINGLE;
		end
	end

	always_comb begin
		s = '0;
		pos = sel;
		if ((mode == MODE_PAIR_BIP) || (mode == MODE_PAIR_UNI)) begin
			// Sequencer never swaps polarity
			if (d.seq_drive) begin
				pos = {sel[2:1], 1'b0};
			end
			s.pos_sel = 8'h01 << pos;
			s.neg_sel = 8'h01 << {pos[2:1], ~pos[0]};
			s.mid_sense = (mode == MODE_PAIR_BIP);
			s.twos_comp = (mode == MODE_PAIR_BIP);
		end else begin
			s.pos_sel = 8'h01 << pos;
			s.neg_is_com = (mode != MODE_SINGLE);
			s.neg_is_gnd = (mode == MODE_SINGLE);
			s.mid_sense  = (mode == MODE_COM_BIP);
			s.twos_comp  = (mode == MODE_COM_BIP);
		end
		s.ref_int_en = (refs == `REF_INT_2V5) || (refs == `REF_INT_4V096);
		s.ref_4v096  = (refs == `REF_INT_4V096);
		s.buf_en     = (refs == `REF_INT_2V5) || (refs == `REF_INT_4V096)
			|| (refs == `REF_EXT_BUF_T) || (refs == `REF_EXT_BUF);
		s.temp_en    = s.ref_int_en || (refs == `REF_EXT_TEMP)
			|| (refs == `REF_EXT_BUF_T);
		if (d.temp_pick) begin
			s.pos_sel    = 8'h00;
			s.neg_sel    = 8'h00;
			s.neg_is_com = 1'b0;
			s.neg_is_gnd = 1'b1;
			s.mid_sense  = 1'b0;
			s.twos_comp  = 1'b0;
		end
	end

	assign d.setting = s;
endmodule // cfg_decode

//--- src/mux_cfg_ctrl.sv
// Input multiplexer and reference configuration controller
//
// Chosen here: the plain strobed port and the register addresses.
`include "mux_cfg_defs.svh"
//------------------------------------------------------------
//------------------------------------------------------------
module mux_cfg_ctrl
	import mux_cfg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic        start,
	input  wire logic        conv_done,
	input  wire logic        seq_drive,
	input  wire logic [2:0]  seq_ch,
	input  wire logic        temp_pick,
	output logic      [15:0] rdata,
	output logic      [7:0]  pos_sel,
	output logic      [7:0]  neg_sel,
	output logic             neg_is_com,
	output logic             neg_is_gnd,
	output logic             mid_sense,
	output logic             twos_comp,
	output logic             ref_int_en,
	output logic             ref_4v096,
	output logic             buf_en,
	output logic             temp_en,
	output logic             sampling
);
	//------------------------------------------------------------
	// Registers
	//------------------------------------------------------------
	logic [13:0]  cfg_reg;
	logic [13:0]  cfg_next;
	logic [15:0]  rdata_reg;
	logic [15:0]  rdata_next;
	mux_setting_t set_reg;
	mux_setting_t set_next;
	samp_state_t  state_reg;
	samp_state_t  state_next;
	logic         seq_reg;
	logic         seq_next;
	logic [2:0]   sch_reg;
	logic [2:0]   sch_next;
	logic         tp_reg;
	logic         tp_next;

	cfg_dec_if dif ();
	assign dif.cfg       = cfg_reg;
	assign dif.seq_drive = seq_reg;
	assign dif.seq_ch    = sch_reg;
	assign dif.temp_pick = tp_reg;

	cfg_decode u_dec (
		.d (dif.dec)
	);

	//------------------------------------------------------------
	// Register port and sample sequencing
	//------------------------------------------------------------
	always_comb begin
		cfg_next   = cfg_reg;
		rdata_next = 16'h0000;
		state_next = state_reg;
		set_next   = set_reg;
		seq_next   = seq_reg;
		sch_next   = sch_reg;
		tp_next    = tp_reg;
		// A write mid-sample lands for the next sample only
		if (wr && (addr == `ADDR_CFG)) begin
			cfg_next = wdata[13:0];
		end else if (wr && (addr == `ADDR_SAMPLE)) begin
			seq_next = wdata[0];
			sch_next = wdata[3:1];
			tp_next  = wdata[4];
		end
		if (rd && (addr == `ADDR_CFG)) begin
			rdata_next = {2'b00, cfg_reg};
		end else if (rd && (addr == `ADDR_SAMPLE)) begin
			rdata_next = {11'h000, tp_reg, sch_reg, seq_reg};
		end else if (rd && (addr == `ADDR_STATUS)) begin
			rdata_next = {14'h0000, (state_reg == ST_CONV), (state_reg != ST_IDLE)};
		end
		case (state_reg)
			ST_IDLE: begin
				set_next = dif.setting;
				if (start) begin
					state_next = ST_ACQ;
				end
			end
			ST_ACQ: begin
				state_next = ST_CONV;
			end
			ST_CONV: begin
				if (conv_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_reg   <= `CFG_RESET;
			rdata_reg <= 16'h0000;
			set_reg   <= '0;
			state_reg <= ST_IDLE;
			seq_reg   <= 1'b0;
			sch_reg   <= 3'h0;
			tp_reg    <= 1'b0;
		end else begin
			cfg_reg   <= cfg_next;
			rdata_reg <= rdata_next;
			set_reg   <= set_next;
			state_reg <= state_next;
			seq_reg   <= seq_next;
			sch_reg   <= sch_next;
			tp_reg    <= tp_next;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	logic samp_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			samp_reg <= 1'b0;
		end else begin
			samp_reg <= (state_next != ST_IDLE);
		end
	end

	assign rdata      = rdata_reg;
	assign pos_sel    = set_reg.pos_sel;
	assign neg_sel    = set_reg.neg_sel;
	assign neg_is_com = set_reg.neg_is_com;
	assign neg_is_gnd = set_reg.neg_is_gnd;
	assign mid_sense  = set_reg.mid_sense;
	assign twos_comp  = set_reg.twos_comp;
	assign ref_int_en = set_reg.ref_int_en;
	assign ref_4v096  = set_reg.ref_4v096;
	assign buf_en     = set_reg.buf_en;
	assign temp_en    = set_reg.temp_en;
	assign sampling   = samp_reg;
endmodule // mux_cfg_ctrl

//--- dv/mux_cfg_ctrl_sva.sv
// Port checks for the input multiplexer and reference controller
module mux_cfg_sva (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       start,
	input wire logic [7:0] pos_sel,
	input wire logic [7:0] neg_sel,
	input wire logic       neg_is_com,
	input wire logic       neg_is_gnd,
	input wire logic       mid_sense,
	input wire logic       twos_comp,
	input wire logic       ref_int_en,
	input wire logic       ref_4v096,
	input wire logic       temp_en,
	input wire logic       sampling
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] mate;
	assign mate = {pos_sel[6], pos_sel[7], pos_sel[4], pos_sel[5],
		pos_sel[2], pos_sel[3], pos_sel[0], pos_sel[1]};
	a_pair_mate: assert property (neg_sel != 8'h00 |-> neg_sel == mate)
		else $error("negative input is not the pair mate");
	a_one_input: assert property ($onehot0(pos_sel) && $onehot0(neg_sel))
		else $error("more than one input selected");
	a_temp_follow: assert property (ref_int_en |-> temp_en)
		else $error("sensor off with internal reference");
	a_ref_size: assert property (ref_4v096 |-> ref_int_en)
		else $error("large reference without internal reference");
	a_bip_format: assert property (twos_comp == mid_sense)
		else $error("format disagrees with mid sense");
	a_uni_format: assert property (neg_is_gnd |-> !twos_comp)
		else $error("ground sense with twos complement");
	a_com_alone: assert property (neg_is_com |-> neg_sel == 8'h00)
		else $error("common input mode with paired negative");
	a_hold_sample: assert property (sampling && $past(sampling) |->
		$stable({pos_sel, neg_sel, neg_is_com, mid_sense, twos_comp, ref_int_en, temp_en}))
		else $error("settings moved during a sample");
	a_start_only: assert property ($rose(sampling) |-> $past(start))
		else $error("sample began without start");
	c_pair_odd: cover property (neg_sel != 8'h00 && (pos_sel & 8'hAA) != 8'h00);
	c_temp_ext: cover property (temp_en && !ref_int_en);
	c_sample_end: cover property ($fell(sampling));
endmodule // mux_cfg_sva

bind mux_cfg_ctrl mux_cfg_sva u_sva (.*);

//--- dv/host_model.sv
// Host side of the register port: one-cycle strobes, lines scrambled when idle
module host_model (
	input  wire logic        clk,
	input  wire logic [15:0] rdata,
	output logic      [3:0]  addr,
	output logic      [15:0] wdata,
	output logic             wr,
	output logic             rd
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr = 4'hF;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic put(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic get(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		// Data stand for one cycle only; take them mid-cycle, clear of the edge
		@(negedge clk);
		d = rdata;
	endtask
endmodule // host_model

//--- dv/adc_input_mux_config_decoder_tb.sv
// Self-checking bench for the input multiplexer and reference controller
`include "mux_cfg_defs.svh"
module adc_input_mux_config_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	logic        conv_done = 1'b0;
	logic        seq_drive = 1'b0;
	logic [2:0]  seq_ch = 3'h0;
	logic        temp_pick = 1'b0;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, got;
	logic        wr, rd, sampling, neg_is_gnd, buf_en, neg_is_com;
	logic        mid_sense, twos_comp, ref_int_en, ref_4v096, temp_en;
	logic [7:0]  pos_sel, neg_sel;
	int          bad_count = 0;
	int          compares = 0;
	int          cycles = 0;
	int          c;
	wire [21:0]  now_set = {pos_sel, neg_sel, neg_is_com, mid_sense, twos_comp,
		ref_int_en, ref_4v096, temp_en};
	mux_cfg_ctrl DUT (.*);
	host_model host (.*);
	initial forever #4 clk = ~clk;
	function automatic logic [21:0] dec(int c);
		int f = (c >> 10) & 7;
		int s = (c >> 7) & 7;
		int r = (c >> 3) & 7;
		logic [7:0] neg = 8'h00;
		logic pair = f inside {0, 1, 4, 5};
		logic mid = f == 2 || (pair && f < 4);
		if (pair) neg = 8'h01 << (s ^ 1);
		return {8'h01 << s, neg, f == 2 || f == 6, mid, mid, r < 2, r == 1, r < 4};
	endfunction
	task automatic chk(string what, logic [21:0] exp, logic [21:0] seen);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic stop_test;
		if (bad_count == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Hang guard, well above the planned run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			stop_test();
		end
	end
	initial begin
		c = $urandom(32'hAC75);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		tick(2);
		chk("reset decode", dec(16'h3FFF), now_set);
		// Every input field and select, random reference code
		for (int i = 0; i < 64; i++) begin
			c = 16'h2000 | (i << 7) | (($urandom % 8) << 3);
			host.put(`ADDR_CFG, 16'(c));
			tick(2);
			chk("decode", dec(c), now_set);
			chk("buffer", 22'(((c >> 3) & 7) inside {0, 1, 3, 7}), 22'(buf_en));
			host.get(`ADDR_CFG, got);
			chk("config readback", 16'(c), got);
		end
		host.put(`ADDR_SAMPLE, 16'h0007);
		host.put(`ADDR_CFG, 16'h2280);
		tick(2);
		chk("sequencer positive", 22'h0, {14'h0, pos_sel & 8'hAA});
		host.put(`ADDR_SAMPLE, 16'h0010);
		tick(2);
		chk("temperature pick", 22'h1, {pos_sel, neg_sel, neg_is_com, mid_sense, twos_comp, 2'h0, neg_is_gnd});
		host.put(`ADDR_SAMPLE, 16'h0000);
		host.put(4'hF, 16'hFFFF);
		host.get(4'hF, got);
		chk("unmapped read", 22'h0, got);
		host.put(`ADDR_CFG, 16'h3C08);
		tick(2);
		@(posedge clk) start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		host.put(`ADDR_CFG, 16'h2338);
		tick(3);
		chk("held settings", dec(16'h3C08), now_set);
		chk("sampling", 22'h1, sampling);
		@(posedge clk) conv_done <= 1'b1;
		for (int n = 0; n < 200 && sampling !== 1'b0; n++) @(posedge clk);
		conv_done <= 1'b0;
		tick(2);
		chk("sample end", 22'h0, 22'(sampling));
		chk("next sample settings", dec(16'h2338), now_set);
		stop_test();
	end
endmodule // adc_input_mux_config_decoder_tb
